// ### src/asp_map.vh
// constants for the asynchronous and burst sram port
// assumes inclusion by the port modules only
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// --------------------------------------------------
// timing
// --------------------------------------------------
`define ASP_MCLK_PERIOD_NS  40
`define ASP_MEMCLK_PERIOD_NS 320

// --------------------------------------------------
// burst sram
// --------------------------------------------------
`define ASP_BURST_LEN      4
`define ASP_BURST_RD_LAT   2

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define ASP_RST_PIN_N      1'h1
`define ASP_RST_DATA      32'h00000000
`define ASP_RST_ADDR      20'h00000

`endif

// ### src/asp_clk_sync.v
// memory clock divider and input synchronisers for the sram port
// assumes mclk is the only clock; ready and read data come from pins
`timescale 1ns/1ps
module asp_clk_sync #(
   parameter HALF = 4,
   parameter DW   = 32
) (
   // clock and reset
   input  wire          mclk,
   input  wire          rstn,
   // pins in
   input  wire          readyIn,
   input  wire [DW-1:0] dataIn,
   // to the sequencer
   output reg           memClk,
   output wire          tick,
   output reg           readySync,
   output reg  [DW-1:0] dataSync
);

   reg [7:0]    divCnt_r;
   reg          readyMeta_r;
   reg [DW-1:0] dataMeta_r;

   // --------------------------------------------------
   // divider; tick marks the memory clock rising edge
   // --------------------------------------------------
   assign tick = (divCnt_r == HALF[7:0] - 8'h01) && !memClk;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         divCnt_r <= 8'h00;
         memClk   <= 1'h0;
      end else if (divCnt_r == HALF[7:0] - 8'h01) begin
         divCnt_r <= 8'h00;
         memClk   <= !memClk;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end

   // --------------------------------------------------
   // two-stage synchronisers
   // --------------------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         readyMeta_r <= 1'h0;
         readySync   <= 1'h0;
         dataMeta_r  <= {DW{1'h0}};
         dataSync    <= {DW{1'h0}};
      end else begin
         readyMeta_r <= readyIn;
         readySync   <= readyMeta_r;
         dataMeta_r  <= dataIn;
         dataSync    <= dataMeta_r;
      end
   end

endmodule // asp_clk_sync

// ### src/asp_sram_port.v
// asynchronous and burst sram sequencer for one chip space
// assumes a requester on mclk and memory pins outside the mclk domain
// Contract
// - read selects valid setup periods before strobe
// - read selects held hold periods after strobe
// - write selects, data valid setup before strobe
// - write selects, data held hold after strobe
// - six timing counts come from configuration
// - select group: cs, lanes, address, oe, data
// - read data captured at strobe rise
// - ready synchronised, acted on at sampling edge
// - async: shared pins are oe, read, write
// - burst: shared pins are ads, oe, we
// - incrementing four-word bursts, first address only
// - new address strobe interrupts burst, no gaps
// - burst signals launched, sampled on clock rise
`timescale 1ns/1ps
`include "asp_map.vh"
module asp_sram_port #(
   parameter CW = 4
) (
   // clock and reset
   input  wire          mclk,
   input  wire          rstn,
   // timing configuration
   input  wire [CW-1:0] readSetupCount,
   input  wire [CW-1:0] readStrobeCount,
   input  wire [CW-1:0] readHoldCount,
   input  wire [CW-1:0] writeSetupCount,
   input  wire [CW-1:0] writeStrobeCount,
   input  wire [CW-1:0] writeHoldCount,
   input  wire          burstMode,
   // request side
   input  wire          reqValid,
   input  wire          reqWrite,
   input  wire [19:0]   reqAddr,
   input  wire [3:0]    reqByteEn,
   input  wire [31:0]   reqWdata,
   output reg           reqAck,
   output reg           rspValid,
   output reg  [31:0]   rspData,
   output reg           busy,
   // memory pins
   output wire          memClockOut,
   output reg           chipSpaceSelectN,
   output reg  [3:0]    byteLaneEnableN,
   output reg  [19:0]   wordAddressOut,
   output reg           sharedOeN,
   output reg           sharedStbN,
   output reg           sharedWeN,
   output reg  [31:0]   memDataOut,
   output reg           memDataOeN,
   input  wire [31:0]   memDataIn,
   input  wire          asyncReadyIn
);

   localparam HALF = `ASP_MEMCLK_PERIOD_NS / (2 * `ASP_MCLK_PERIOD_NS);
   localparam LAT  = `ASP_BURST_RD_LAT;

   localparam ST_IDLE   = 3'h0;
   localparam ST_SETUP  = 3'h1;
   localparam ST_STROBE = 3'h2;
   localparam ST_HOLD   = 3'h3;
   localparam ST_BURST  = 3'h4;

   wire          tick;
   wire          readySync;
   wire [31:0]   dataSync;
   reg  [2:0]    state_r;
   reg  [CW-1:0] cnt_r;
   reg           isWrite_r;
   reg  [1:0]    beat_r;
   reg  [19:0]   nextAddr_r;
   reg  [LAT-1:0] rdPipe_r;
   reg           contBeat;

   // counts of zero behave as one period
   function [CW-1:0] loadCnt;
      input [CW-1:0] v;
      begin
         loadCnt = (v == {CW{1'h0}}) ? {CW{1'h0}} : v - {{(CW-1){1'h0}}, 1'h1};
      end
   endfunction

   // --------------------------------------------------
   // memory clock and synchronisers
   // --------------------------------------------------
   asp_clk_sync #(
      .HALF (HALF),
      .DW   (32)
   ) u_clk_sync (
      .mclk      (mclk),
      .rstn      (rstn),
      .readyIn   (asyncReadyIn),
      .dataIn    (memDataIn),
      .memClk    (memClockOut),
      .tick      (tick),
      .readySync (readySync),
      .dataSync  (dataSync)
   );

   // burst continues without a new strobe when address follows on
   always @* begin
      contBeat = reqValid && (reqWrite == isWrite_r) && (reqAddr == nextAddr_r)
                 && (beat_r != 2'h3);
   end

   // --------------------------------------------------
   // sequencer; every pin and state change sits on a tick, reqAck and rspValid clear on the next mclk
   // --------------------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r          <= ST_IDLE;
         cnt_r            <= {CW{1'h0}};
         isWrite_r        <= 1'h0;
         beat_r           <= 2'h0;
         nextAddr_r       <= `ASP_RST_ADDR;
         rdPipe_r         <= {LAT{1'h0}};
         reqAck           <= 1'h0;
         rspValid         <= 1'h0;
         rspData          <= `ASP_RST_DATA;
         busy             <= 1'h0;
         chipSpaceSelectN <= `ASP_RST_PIN_N;
         byteLaneEnableN  <= 4'hF;
         wordAddressOut   <= `ASP_RST_ADDR;
         sharedOeN        <= `ASP_RST_PIN_N;
         sharedStbN       <= `ASP_RST_PIN_N;
         sharedWeN        <= `ASP_RST_PIN_N;
         memDataOut       <= `ASP_RST_DATA;
         memDataOeN       <= 1'h1;
      end else begin
         reqAck   <= 1'h0;
         rspValid <= 1'h0;
         if (tick) begin
            case (state_r)
               ST_IDLE: begin
                  if (reqValid && burstMode) begin
                     state_r <= ST_BURST;
                  end else if (reqValid) begin
                     // present select group, setup phase starts
                     reqAck           <= 1'h1;
                     busy             <= 1'h1;
                     isWrite_r        <= reqWrite;
                     chipSpaceSelectN <= 1'h0;
                     byteLaneEnableN  <= ~reqByteEn;
                     wordAddressOut   <= reqAddr;
                     sharedOeN        <= reqWrite;
                     memDataOut       <= reqWdata;
                     memDataOeN       <= !reqWrite;
                     cnt_r            <= reqWrite ? loadCnt(writeSetupCount)
                                                  : loadCnt(readSetupCount);
                     state_r          <= ST_SETUP;
                  end
               end
               ST_SETUP: begin
                  if (cnt_r == {CW{1'h0}}) begin
                     sharedStbN <= isWrite_r;
                     sharedWeN  <= !isWrite_r;
                     cnt_r      <= isWrite_r ? loadCnt(writeStrobeCount)
                                             : loadCnt(readStrobeCount);
                     state_r    <= ST_STROBE;
                  end else begin
                     cnt_r <= cnt_r - {{(CW-1){1'h0}}, 1'h1};
                  end
               end
               ST_STROBE: begin
                  if (cnt_r != {CW{1'h0}}) begin
                     cnt_r <= cnt_r - {{(CW-1){1'h0}}, 1'h1};
                  end else if (readySync) begin
                     sharedStbN <= 1'h1;
                     sharedWeN  <= 1'h1;
                     if (!isWrite_r) begin
                        rspValid <= 1'h1;
                        rspData  <= dataSync;
                     end
                     cnt_r   <= isWrite_r ? loadCnt(writeHoldCount)
                                          : loadCnt(readHoldCount);
                     state_r <= ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  if (cnt_r == {CW{1'h0}}) begin
                     chipSpaceSelectN <= 1'h1;
                     byteLaneEnableN  <= 4'hF;
                     sharedOeN        <= 1'h1;
                     memDataOeN       <= 1'h1;
                     busy             <= 1'h0;
                     state_r          <= ST_IDLE;
                  end else begin
                     cnt_r <= cnt_r - {{(CW-1){1'h0}}, 1'h1};
                  end
               end
               ST_BURST: begin
                  // read data returns a fixed number of rises later
                  rdPipe_r <= {rdPipe_r[LAT-2:0], 1'h0};
                  if (rdPipe_r[LAT-1]) begin
                     rspValid <= 1'h1;
                     rspData  <= dataSync;
                  end
                  if (reqValid && burstMode) begin
                     reqAck           <= 1'h1;
                     busy             <= 1'h1;
                     isWrite_r        <= reqWrite;
                     chipSpaceSelectN <= 1'h0;
                     byteLaneEnableN  <= ~reqByteEn;
                     nextAddr_r       <= reqAddr + 20'h00001;
                     sharedOeN        <= reqWrite;
                     sharedWeN        <= !reqWrite;
                     memDataOut       <= reqWdata;
                     memDataOeN       <= !reqWrite;
                     rdPipe_r[0]      <= !reqWrite;
                     if (contBeat && !(state_r == ST_BURST && busy == 1'h0)) begin
                        sharedStbN <= 1'h1;
                        beat_r     <= beat_r + 2'h1;
                     end else begin
                        sharedStbN     <= 1'h0;
                        wordAddressOut <= reqAddr;
                        beat_r         <= 2'h0;
                     end
                  end else begin
                     chipSpaceSelectN <= 1'h1;
                     byteLaneEnableN  <= 4'hF;
                     sharedStbN       <= 1'h1;
                     sharedWeN        <= 1'h1;
                     memDataOeN       <= 1'h1;
                     busy             <= 1'h0;
                     if (!rdPipe_r[LAT-2] || !sharedOeN) begin
                        if (rdPipe_r == {LAT{1'h0}}) begin
                           sharedOeN <= 1'h1;
                           state_r   <= ST_IDLE;
                        end
                     end
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule // asp_sram_port

// ### tb/asp_sram_port_asserts.sv
// checker for the sram port sequencer pins
// assumes binding into asp_sram_port, one mclk domain
`timescale 1ns/1ps
module asp_sram_port_asserts #(
   parameter CW = 4
) (
   // clock and reset
   input wire          mclk,
   input wire          rstn,
   // configuration
   input wire [CW-1:0] readSetupCount,
   input wire [CW-1:0] readStrobeCount,
   input wire [CW-1:0] readHoldCount,
   input wire [CW-1:0] writeSetupCount,
   input wire [CW-1:0] writeHoldCount,
   input wire          burstMode,
   // design outputs
   input wire          reqAck,
   input wire          rspValid,
   input wire          memClockOut,
   input wire          chipSpaceSelectN,
   input wire [19:0]   wordAddressOut,
   input wire          sharedOeN,
   input wire          sharedStbN,
   input wire          sharedWeN,
   input wire          memDataOeN
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   reg [15:0] phCnt_r;
   reg [2:0]  grp_r;
   function automatic int e8(input logic [CW-1:0] v);
      return (v == 0) ? 8 : 8 * v;
   endfunction
   // mclk cycles since select or strobe last moved
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phCnt_r <= 16'h0000;
         grp_r   <= 3'h7;
      end else begin
         grp_r   <= {chipSpaceSelectN, sharedStbN, sharedWeN};
         phCnt_r <= (grp_r != {chipSpaceSelectN, sharedStbN, sharedWeN}) ? 16'h0001 : phCnt_r + 16'h0001;
      end
   end
   a_read_setup: assert property (!burstMode && $fell(sharedStbN) |-> phCnt_r == e8(readSetupCount))
      else $error("read setup length wrong");
   a_write_setup: assert property (!burstMode && $fell(sharedWeN) |-> phCnt_r == e8(writeSetupCount) && !memDataOeN)
      else $error("write setup length wrong");
   a_read_hold: assert property (!burstMode && $rose(chipSpaceSelectN) && !$past(sharedOeN) |-> phCnt_r == e8(readHoldCount))
      else $error("read hold length wrong");
   a_write_hold: assert property (!burstMode && $rose(chipSpaceSelectN) && !$past(memDataOeN) |-> phCnt_r == e8(writeHoldCount))
      else $error("write hold length wrong");
   a_strobe_len_capture: assert property (!burstMode && $rose(sharedStbN) |-> phCnt_r >= e8(readStrobeCount) && phCnt_r[2:0] == 3'h0 && rspValid)
      else $error("read strobe length or capture wrong");
   a_pins_on_tick: assert property ($changed({chipSpaceSelectN, wordAddressOut, sharedOeN, sharedStbN, sharedWeN, memDataOeN}) |-> $rose(memClockOut))
      else $error("pin changed off memory clock rise");
   a_mem_clock_duty: assert property ($rose(memClockOut) |-> ##4 $fell(memClockOut))
      else $error("memory clock high time wrong");
   a_oe_in_select: assert property (!memDataOeN || (!burstMode && !sharedOeN) |-> !chipSpaceSelectN)
      else $error("enable outside select");
   a_burst_select: assert property (burstMode && (!sharedStbN || !sharedWeN) |-> !chipSpaceSelectN)
      else $error("burst strobe without select");
   c_slow_read: cover property (!burstMode && $rose(sharedStbN) && phCnt_r > e8(readStrobeCount));
   c_async_write: cover property (!burstMode && $fell(sharedWeN));
   c_burst_restrobe: cover property (burstMode && !sharedStbN && reqAck);
   c_burst_read: cover property (burstMode && rspValid);
endmodule // asp_sram_port_asserts
bind asp_sram_port asp_sram_port_asserts #(.CW(CW)) u_chk (.mclk(mclk), .rstn(rstn),
   .readSetupCount(readSetupCount), .readStrobeCount(readStrobeCount), .readHoldCount(readHoldCount),
   .writeSetupCount(writeSetupCount), .writeHoldCount(writeHoldCount), .burstMode(burstMode), .reqAck(reqAck),
   .rspValid(rspValid), .memClockOut(memClockOut), .chipSpaceSelectN(chipSpaceSelectN),
   .wordAddressOut(wordAddressOut), .sharedOeN(sharedOeN), .sharedStbN(sharedStbN), .sharedWeN(sharedWeN),
   .memDataOeN(memDataOeN));

// ### tb/asp_mem_model.sv
// behavioural sram on the memory pins, async or burst
// assumes pins launched at memory clock rise, sampled here at its fall, except async writes, taken at the write enable rise
`timescale 1ns/1ps
module asp_mem_model (
   // pins from the port
   input wire         memClockOut,
   input wire         burstMode,
   input wire         chipSpaceSelectN,
   input wire [3:0]   byteLaneEnableN,
   input wire [19:0]  wordAddressOut,
   input wire         sharedOeN,
   input wire         sharedStbN,
   input wire         sharedWeN,
   input wire [31:0]  memDataOut,
   // not-ready periods per strobe
   input wire [1:0]   slowTicks,
   // pins to the port
   output wire [31:0] memDataIn,
   output reg         asyncReadyIn
);
   reg [31:0] mem [0:15];
   reg [3:0]  burstAddr_r;
   reg [1:0]  waitCnt_r;
   reg [3:0]  rdA_r;
   reg [31:0] rdQ_r;
   integer    i;
   wire [3:0] wa = (burstMode && sharedStbN) ? burstAddr_r : wordAddressOut[3:0];
   // async data only while selected and enabled, inverted otherwise
   // burst reads come from a two-fall pipeline while the burst output enable is low
   assign memDataIn = (!chipSpaceSelectN && !sharedOeN && !burstMode) ? mem[wa] :
                      (burstMode && !sharedOeN) ? rdQ_r : ~mem[wa];
   task wr;
      for (i = 0; i < 4; i = i + 1)
         if (!byteLaneEnableN[i]) mem[wa][8*i +: 8] = memDataOut[8*i +: 8];
   endtask
   initial begin
      for (i = 0; i < 16; i = i + 1) mem[i] = 32'h00000000;
      asyncReadyIn = 1'b1;
      waitCnt_r = 2'h0;
   end
   always @(posedge sharedWeN) if (!chipSpaceSelectN && !burstMode) wr;
   always @(negedge memClockOut) begin
      if (burstMode && !chipSpaceSelectN) begin
         if (!sharedWeN) wr;
         burstAddr_r <= wa + 4'h1;
      end
      rdA_r <= wa;
      rdQ_r <= mem[rdA_r];
      if (!chipSpaceSelectN && !burstMode && !(sharedStbN && sharedWeN)) begin
         asyncReadyIn <= (waitCnt_r >= slowTicks);
         if (waitCnt_r != 2'h3) waitCnt_r <= waitCnt_r + 2'h1;
      end else begin
         asyncReadyIn <= 1'b1;
         waitCnt_r <= 2'h0;
      end
   end
endmodule // asp_mem_model

// ### tb/asp_sram_port_tb_top.sv
// self-checking bench for the sram port sequencer
// assumes asp_mem_model on the pins and the bound checker
`timescale 1ns/1ps
module asp_sram_port_tb_top;
   reg mclk = 1'b0, rstn = 1'b0, burstMode = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
   reg [3:0] cnt [0:5];
   reg [19:0] reqAddr = 20'h00000;
   reg [3:0] reqByteEn = 4'h0, a, b;
   reg [31:0] reqWdata = 32'h00000000, d;
   reg [31:0] expMem [0:15];
   reg [1:0] slowTicks = 2'h0;
   wire reqAck, rspValid, busy, memClockOut, chipSpaceSelectN, sharedOeN, sharedStbN, sharedWeN, memDataOeN;
   wire asyncReadyIn;
   wire [31:0] rspData, memDataOut, memDataIn;
   wire [3:0] byteLaneEnableN;
   wire [19:0] wordAddressOut;
   integer seed = 32'h2F6D44DA, errCount = 0, samplesChecked = 0, i, k, n, m, w;
   asp_sram_port #(.CW(4)) i_dut (.mclk(mclk), .rstn(rstn), .readSetupCount(cnt[0]), .readStrobeCount(cnt[1]),
      .readHoldCount(cnt[2]), .writeSetupCount(cnt[3]), .writeStrobeCount(cnt[4]), .writeHoldCount(cnt[5]),
      .burstMode(burstMode), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
      .reqWdata(reqWdata), .reqAck(reqAck), .rspValid(rspValid), .rspData(rspData), .busy(busy),
      .memClockOut(memClockOut), .chipSpaceSelectN(chipSpaceSelectN), .byteLaneEnableN(byteLaneEnableN),
      .wordAddressOut(wordAddressOut), .sharedOeN(sharedOeN), .sharedStbN(sharedStbN), .sharedWeN(sharedWeN),
      .memDataOut(memDataOut), .memDataOeN(memDataOeN), .memDataIn(memDataIn), .asyncReadyIn(asyncReadyIn));
   asp_mem_model i_mem (.memClockOut(memClockOut), .burstMode(burstMode), .chipSpaceSelectN(chipSpaceSelectN),
      .byteLaneEnableN(byteLaneEnableN), .wordAddressOut(wordAddressOut), .sharedOeN(sharedOeN),
      .sharedStbN(sharedStbN), .sharedWeN(sharedWeN), .memDataOut(memDataOut), .slowTicks(slowTicks),
      .memDataIn(memDataIn), .asyncReadyIn(asyncReadyIn));
   always #20 mclk = ~mclk;
   // ----------------------------------------
   // checks and bus tasks
   // ----------------------------------------
   function [31:0] merge(input [31:0] o, input [31:0] nw, input [3:0] be);
      integer j;
      begin
         merge = o;
         for (j = 0; j < 4; j = j + 1) if (be[j]) merge[8*j +: 8] = nw[8*j +: 8];
      end
   endfunction
   task chk(input [8*8-1:0] nm, input [31:0] ex, input [31:0] got);
      begin
         samplesChecked = samplesChecked + 1;
         if (got !== ex) begin
            errCount = errCount + 1;
            $display("FAIL %0s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task req(input w, input [3:0] ad, input [3:0] be, input [31:0] wd);
      begin
         reqValid <= 1'b1;
         reqWrite <= w;
         reqAddr <= {16'h0000, ad};
         reqByteEn <= be;
         reqWdata <= wd;
         n = 0;
         do begin @(posedge mclk); n = n + 1; end while (reqAck !== 1'b1 && n < 40);
         chk("ack", 32'h1, {31'h0, reqAck});
      end
   endtask
   task idle;
      begin
         reqValid <= 1'b0;
         k = 0;
         do begin @(posedge mclk); k = k + 1; end while (busy !== 1'b0 && k < 400);
         chk("idle", 32'h0, {31'h0, busy});
      end
   endtask
   task rd(input [3:0] ad);
      begin
         req(1'b0, ad, 4'hF, 32'h00000000);
         reqValid <= 1'b0;
         n = 0;
         while (rspValid !== 1'b1 && n < 400) begin @(posedge mclk); n = n + 1; end
         chk("rvalid", 32'h1, {31'h0, rspValid});
         chk("rdata", expMem[ad], rspData);
         idle;
      end
   endtask
   task report_and_stop;
      begin
         $display("checked %0d mismatches %0d", samplesChecked, errCount);
         if (errCount == 0 && samplesChecked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      for (i = 0; i < 16; i = i + 1) expMem[i] = 32'h00000000;
      for (i = 0; i < 6; i = i + 1) cnt[i] <= 4'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk("idlepins", 32'h1F, {27'h0, chipSpaceSelectN, sharedOeN, sharedStbN, sharedWeN, memDataOeN});
      for (k = 0; k < 40; k = k + 1) begin
         for (i = 0; i < 6; i = i + 1) cnt[i] <= (k == 0) ? 4'hF : $random(seed) & 4'h3;
         slowTicks <= ($random(seed) & 1) ? 2'h2 : 2'h0;
         a = $random(seed);
         d = $random(seed);
         b = $random(seed);
         expMem[a] = merge(expMem[a], d, b);
         req(1'b1, a, b, d);
         i = k;
         idle;
         k = i;
         rd(a);
         k = i;
      end
      burstMode <= 1'b1;
      a = $random(seed) & 4'h7;
      for (i = 0; i < 6; i = i + 1) begin
         d = $random(seed);
         expMem[a + ((i == 5) ? 4'h1 : i)] = d;
         req(1'b1, a + ((i == 5) ? 4'h1 : i), 4'hF, d);
         if (i > 0) chk("gap", 32'h8, n);
      end
      idle;
      // burst reads back to back while a second process collects the data
      fork
         begin
            for (i = 0; i < 5; i = i + 1) req(1'b0, a + i, 4'hF, 32'h00000000);
            reqValid <= 1'b0;
         end
         for (m = 0; m < 5; m = m + 1) begin
            w = 0;
            do begin @(posedge mclk); w = w + 1; end while (rspValid !== 1'b1 && w < 40);
            chk("brvalid", 32'h1, {31'h0, rspValid});
            chk("brdata", expMem[a + m], rspData);
         end
      join
      idle;
      // let the read pipeline drain before leaving burst mode
      repeat (16) @(posedge mclk);
      burstMode <= 1'b0;
      for (i = 0; i < 5; i = i + 1) rd(a + i);
      report_and_stop;
   end
   initial begin
      #2000000;
      errCount = errCount + 1;
      report_and_stop;
   end
endmodule // asp_sram_port_tb_top
